// File: rtl/berr_regs.sv
// Function
// - Correctable flags 0,6,7,8,12 sticky write-one-clear
// - Correctable mask bits sticky, reset zero
// - Pointer sticky read-only, capable bits one, enables
// - Header log four words, byte0 in top
// - Far-side flags 0-3,5-13 write-one-clear, rest zero
// - Bridge-internal and far-side events set flags
// - Far-side mask sticky with mixed reset values
// - Far-side severity sticky, bits 6,8,9,12 one
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module berr_regs
(
  input  wire logic                       CLOCK,
  input  wire logic                       RST_N,
  input  wire logic                       LINK_RST_N,
  input  wire berr_pkg::berr_axi_req_type AXI_REQ,
  output berr_pkg::berr_axi_rsp_type      AXI_RSP,
  input  wire logic [31:0]                COR_EVENTS,
  input  wire logic [31:0]                SEC_EVENTS,
  input  wire berr_pkg::berr_log_type     LOG_CAPTURE,
  output logic                            ECRC_GEN_EN,
  output logic                            ECRC_CHK_EN,
  output logic                            COR_REPORT,
  output logic                            SEC_REPORT_FATAL,
  output logic                            SEC_REPORT_NONFATAL
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic addr_hit(input logic [berr_pkg::ADDR_W-1:0] a);
    logic [berr_pkg::ADDR_W-1:0] w;
    w = {a[berr_pkg::ADDR_W-1:2], 2'b00};
    return (w >= berr_pkg::OFS_COR) && (w <= berr_pkg::OFS_SECSEV);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  berr_pkg::berr_wr_type       wr_state_q, wr_state_d;
  berr_pkg::berr_rd_type       rd_state_q, rd_state_d;
  logic                        aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [berr_pkg::ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0]                 wdata_q, wdata_d;
  logic [3:0]                  wstrb_q, wstrb_d;
  logic [1:0]                  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]                 rdata_q, rdata_d;
  logic                        wr_do;
  logic                        aw_rdy, w_rdy, ar_rdy;
  logic [31:0]                 rd_word;

  always_comb
  begin
    wr_state_d = wr_state_q;
    rd_state_d = rd_state_q;
    aw_held_d  = aw_held_q;
    w_held_d   = w_held_q;
    waddr_d    = waddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bresp_d    = bresp_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    wr_do      = 1'b0;
    aw_rdy     = (wr_state_q == berr_pkg::WR_COLLECT) && !aw_held_q;
    w_rdy      = (wr_state_q == berr_pkg::WR_COLLECT) && !w_held_q;
    ar_rdy     = (rd_state_q == berr_pkg::RD_IDLE);
    if (AXI_REQ.awvalid && aw_rdy)
    begin
      aw_held_d = 1'b1;
      waddr_d   = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && w_rdy)
    begin
      w_held_d = 1'b1;
      wdata_d  = AXI_REQ.wdata;
      wstrb_d  = AXI_REQ.wstrb;
    end
    case (wr_state_q)
      berr_pkg::WR_COLLECT:
      begin
        if (aw_held_q && w_held_q)
        begin
          wr_do      = 1'b1;
          aw_held_d  = 1'b0;
          w_held_d   = 1'b0;
          wr_state_d = berr_pkg::WR_RESP;
          bresp_d    = addr_hit(waddr_q) ? berr_pkg::RESP_OKAY : berr_pkg::RESP_SLVERR;
        end
      end
      berr_pkg::WR_RESP:
      begin
        if (AXI_REQ.bready)
        begin
          wr_state_d = berr_pkg::WR_COLLECT;
        end
      end
      default:
      begin
        wr_state_d = berr_pkg::WR_COLLECT;
      end
    endcase
    case (rd_state_q)
      berr_pkg::RD_IDLE:
      begin
        if (AXI_REQ.arvalid)
        begin
          rd_state_d = berr_pkg::RD_RESP;
          rdata_d    = rd_word;
          rresp_d    = addr_hit(AXI_REQ.araddr) ? berr_pkg::RESP_OKAY : berr_pkg::RESP_SLVERR;
        end
      end
      berr_pkg::RD_RESP:
      begin
        if (AXI_REQ.rready)
        begin
          rd_state_d = berr_pkg::RD_IDLE;
        end
      end
      default:
      begin
        rd_state_d = berr_pkg::RD_IDLE;
      end
    endcase
  end

  // Bus state is not sticky: a link reset drops any transfer in flight
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_state_q <= berr_pkg::WR_COLLECT;
      rd_state_q <= berr_pkg::RD_IDLE;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      waddr_q    <= '0;
      wdata_q    <= berr_pkg::ZERO32;
      wstrb_q    <= 4'h0;
      bresp_q    <= berr_pkg::RESP_OKAY;
      rresp_q    <= berr_pkg::RESP_OKAY;
      rdata_q    <= berr_pkg::ZERO32;
    end
    else if (!LINK_RST_N)
    begin
      wr_state_q <= berr_pkg::WR_COLLECT;
      rd_state_q <= berr_pkg::RD_IDLE;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
    end
    else
    begin
      wr_state_q <= wr_state_d;
      rd_state_q <= rd_state_d;
      aw_held_q  <= aw_held_d;
      w_held_q   <= w_held_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bresp_q    <= bresp_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
    end
  end

  // One driver for the whole response struct
  assign AXI_RSP = '{awready: aw_rdy, wready: w_rdy, bvalid: (wr_state_q == berr_pkg::WR_RESP), bresp: bresp_q,
                     arready: ar_rdy, rvalid: (rd_state_q == berr_pkg::RD_RESP), rdata: rdata_q, rresp: rresp_q};

  ////////////////////////////////////////////////////////////////////////////
  // Sticky registers

  logic [31:0]                 cor_q, cor_d, cmask_q, cmask_d;
  logic [31:0]                 sec_q, sec_d, smask_q, smask_d, ssev_q, ssev_d;
  logic [4:0]                  fep_q, fep_d;
  logic                        gen_q, gen_d, chk_q, chk_d;
  logic [berr_pkg::HDR_W-1:0]  hdr_q, hdr_d;
  logic [31:0]                 bm, cap_word;
  logic [berr_pkg::ADDR_W-1:0] wa;

  always_comb
  begin
    bm      = lane_mask(wstrb_q);
    wa      = {waddr_q[berr_pkg::ADDR_W-1:2], 2'b00};
    cor_d   = cor_q;
    sec_d   = sec_q;
    cmask_d = cmask_q;
    smask_d = smask_q;
    ssev_d  = ssev_q;
    gen_d   = gen_q;
    chk_d   = chk_q;
    fep_d   = fep_q;
    hdr_d   = hdr_q;
    if (wr_do)
    begin
      case (wa)
        berr_pkg::OFS_COR:     cor_d   = cor_q & ~(wdata_q & bm);
        berr_pkg::OFS_CORMASK: cmask_d = ((cmask_q & ~bm) | (wdata_q & bm)) & berr_pkg::COR_IMPL;
        berr_pkg::OFS_CAP:
        begin
          if (bm[berr_pkg::GEN_EN_BIT]) gen_d = wdata_q[berr_pkg::GEN_EN_BIT];
          if (bm[berr_pkg::CHK_EN_BIT]) chk_d = wdata_q[berr_pkg::CHK_EN_BIT];
        end
        berr_pkg::OFS_SEC:     sec_d   = sec_q & ~(wdata_q & bm);
        berr_pkg::OFS_SECMASK: smask_d = ((smask_q & ~bm) | (wdata_q & bm)) & berr_pkg::SEC_IMPL;
        berr_pkg::OFS_SECSEV:  ssev_d  = ((ssev_q & ~bm) | (wdata_q & bm)) & berr_pkg::SEC_IMPL;
        default:               cor_d   = cor_q;
      endcase
    end
    // Set after clear, so an event in the clearing cycle is kept
    cor_d = cor_d | (COR_EVENTS & berr_pkg::COR_IMPL);
    sec_d = sec_d | (SEC_EVENTS & berr_pkg::SEC_IMPL);
    if (LOG_CAPTURE.valid)
    begin
      fep_d = LOG_CAPTURE.pointer;
      hdr_d = LOG_CAPTURE.header;
    end
  end

  // Only power-on reset touches these; link reset is deliberately ignored
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cor_q   <= berr_pkg::COR_RST;
      cmask_q <= berr_pkg::COR_RST;
      sec_q   <= berr_pkg::ZERO32;
      smask_q <= berr_pkg::SECMASK_RST;
      ssev_q  <= berr_pkg::SECSEV_RST;
      gen_q   <= 1'b0;
      chk_q   <= 1'b0;
      fep_q   <= 5'h00;
      hdr_q   <= '0;
    end
    else
    begin
      cor_q   <= cor_d;
      cmask_q <= cmask_d;
      sec_q   <= sec_d;
      smask_q <= smask_d;
      ssev_q  <= ssev_d;
      gen_q   <= gen_d;
      chk_q   <= chk_d;
      fep_q   <= fep_d;
      hdr_q   <= hdr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb
  begin
    cap_word = berr_pkg::ZERO32;
    cap_word[berr_pkg::FEP_HI:0]      = fep_q;
    cap_word[berr_pkg::GEN_CAP_BIT]   = 1'b1;
    cap_word[berr_pkg::GEN_EN_BIT]    = gen_q;
    cap_word[berr_pkg::CHK_CAP_BIT]   = 1'b1;
    cap_word[berr_pkg::CHK_EN_BIT]    = chk_q;
    case ({AXI_REQ.araddr[berr_pkg::ADDR_W-1:2], 2'b00})
      berr_pkg::OFS_COR:     rd_word = cor_q;
      berr_pkg::OFS_CORMASK: rd_word = cmask_q;
      berr_pkg::OFS_CAP:     rd_word = cap_word;
      berr_pkg::OFS_HDR0:    rd_word = hdr_q[berr_pkg::HDR_W-1 -: berr_pkg::WORD_W];
      berr_pkg::OFS_HDR1:    rd_word = hdr_q[berr_pkg::HDR_W-1-berr_pkg::WORD_W -: berr_pkg::WORD_W];
      berr_pkg::OFS_HDR2:    rd_word = hdr_q[berr_pkg::WORD_W +: berr_pkg::WORD_W];
      berr_pkg::OFS_HDR3:    rd_word = hdr_q[berr_pkg::WORD_W-1:0];
      berr_pkg::OFS_SEC:     rd_word = sec_q;
      berr_pkg::OFS_SECMASK: rd_word = smask_q;
      berr_pkg::OFS_SECSEV:  rd_word = ssev_q;
      default:               rd_word = berr_pkg::ZERO32;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error reports

  logic cor_rep_d, fat_d, nfat_d, cor_rep_q, fat_q, nfat_q;
  logic [31:0] sec_live;

  always_comb
  begin
    sec_live  = SEC_EVENTS & berr_pkg::SEC_IMPL & ~smask_q;
    cor_rep_d = |(COR_EVENTS & berr_pkg::COR_IMPL & ~cmask_q);
    fat_d     = |(sec_live & ssev_q);
    nfat_d    = |(sec_live & ~ssev_q);
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cor_rep_q <= 1'b0;
      fat_q     <= 1'b0;
      nfat_q    <= 1'b0;
    end
    else
    begin
      cor_rep_q <= cor_rep_d;
      fat_q     <= fat_d;
      nfat_q    <= nfat_d;
    end
  end

  assign COR_REPORT          = cor_rep_q;
  assign SEC_REPORT_FATAL    = fat_q;
  assign SEC_REPORT_NONFATAL = nfat_q;
  assign ECRC_GEN_EN         = gen_q;
  assign ECRC_CHK_EN         = chk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  cor_set_a: assert property ((|(COR_EVENTS & berr_pkg::COR_IMPL)) |=>
    ((cor_q & $past(COR_EVENTS & berr_pkg::COR_IMPL)) == $past(COR_EVENTS & berr_pkg::COR_IMPL)))
    else $error("correctable event not recorded");
  cor_resv_a: assert property ((cor_q & ~berr_pkg::COR_IMPL) == 32'h0000_0000)
    else $error("correctable reserved bit set");
  mask_resv_a: assert property ((cmask_q & ~berr_pkg::COR_IMPL) == 32'h0000_0000)
    else $error("correctable mask reserved bit set");
  cap_read_a: assert property ((AXI_REQ.arvalid && AXI_RSP.arready &&
    ({AXI_REQ.araddr[berr_pkg::ADDR_W-1:2], 2'b00} == berr_pkg::OFS_CAP)) |=>
    AXI_RSP.rvalid && AXI_RSP.rdata[berr_pkg::GEN_CAP_BIT] && AXI_RSP.rdata[berr_pkg::CHK_CAP_BIT])
    else $error("capable bits not read as one");
  hdr_take_a: assert property (LOG_CAPTURE.valid |=> hdr_q == $past(LOG_CAPTURE.header))
    else $error("header not captured");
  sec_resv_a: assert property ((sec_q & ~berr_pkg::SEC_IMPL) == 32'h0000_0000)
    else $error("far-side reserved bit set");
  internal_set_a: assert property (SEC_EVENTS[13] |=> sec_q[13])
    else $error("internal bridge error not recorded");
  sev_resv_a: assert property (((ssev_q | smask_q) & ~berr_pkg::SEC_IMPL) == 32'h0000_0000)
    else $error("mask or severity reserved bit set");
  cor_report_a: assert property ((|(COR_EVENTS & ~cmask_q & berr_pkg::COR_IMPL)) |=> COR_REPORT)
    else $error("correctable report wrong");
  masked_quiet_a: assert property (!(|(COR_EVENTS & ~cmask_q & berr_pkg::COR_IMPL)) |=> !COR_REPORT)
    else $error("masked correctable error reported");
  fatal_split_a: assert property (SEC_REPORT_FATAL |->
    $past(|(SEC_EVENTS & ssev_q & ~smask_q & berr_pkg::SEC_IMPL)))
    else $error("fatal report without fatal cause");
  sticky_hold_a: assert property ((!LINK_RST_N && !wr_do && COR_EVENTS == 32'h0000_0000)
    |=> cor_q == $past(cor_q))
    else $error("sticky flag lost on link reset");
  bvalid_hold_a: assert property (AXI_RSP.bvalid && !AXI_REQ.bready && LINK_RST_N |=> AXI_RSP.bvalid)
    else $error("write response dropped");

endmodule

// File: rtl/berr_pkg.sv
package berr_pkg;
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] OFS_COR     = 12'h110;
  localparam logic [11:0] OFS_CORMASK = 12'h114;
  localparam logic [11:0] OFS_CAP     = 12'h118;
  localparam logic [11:0] OFS_HDR0    = 12'h11C;
  localparam logic [11:0] OFS_HDR1    = 12'h120;
  localparam logic [11:0] OFS_HDR2    = 12'h124;
  localparam logic [11:0] OFS_HDR3    = 12'h128;
  localparam logic [11:0] OFS_SEC     = 12'h12C;
  localparam logic [11:0] OFS_SECMASK = 12'h130;
  localparam logic [11:0] OFS_SECSEV  = 12'h134;
  // Implemented bits of the correctable and far-side groups
  localparam logic [31:0] COR_IMPL    = 32'h0000_11C1;
  localparam logic [31:0] SEC_IMPL    = 32'h0000_3FEF;
  localparam logic [31:0] COR_RST     = 32'h0000_0000;
  localparam logic [31:0] SECMASK_RST = 32'h0000_17A8;
  localparam logic [31:0] SECSEV_RST  = 32'h0000_1340;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  localparam int          FEP_HI      = 4;
  localparam int          GEN_CAP_BIT = 5;
  localparam int          GEN_EN_BIT  = 6;
  localparam int          CHK_CAP_BIT = 7;
  localparam int          CHK_EN_BIT  = 8;
  localparam int          HDR_W       = 128;
  localparam int          WORD_W      = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } berr_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } berr_axi_rsp_type;

  typedef struct packed {
    logic             valid;
    logic [4:0]       pointer;
    logic [HDR_W-1:0] header;
  } berr_log_type;

  typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESP = 1'b1} berr_wr_type;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESP = 1'b1} berr_rd_type;
endpackage

// File: verif/berr_host.sv
`timescale 1ns/100ps
module berr_host
(
  input  wire logic                       clock,
  output berr_pkg::berr_axi_req_type      req,
  input  wire berr_pkg::berr_axi_rsp_type rsp
);
  // Waits are bounded; an expired wait is counted for the bench
  int timeouts = 0;

  initial req = '0;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    while ((aw || w) && n < 100)
    begin
      @(posedge clock);
      n++;
      if (aw && rsp.awready === 1'b1)
      begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1)
      begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    req.bready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.bvalid !== 1'b1 && n < 200);
    r = rsp.bresp;
    req.bready <= 1'b0;
    if (n >= 200)
      timeouts++;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.arready !== 1'b1 && n < 100);
    req.arvalid <= 1'b0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.rvalid !== 1'b1 && n < 200);
    q = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    if (n >= 200)
      timeouts++;
  endtask
endmodule

// File: verif/test_berr_regs.sv
`timescale 1ns/100ps
module test_berr_regs;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] rst;
    logic [31:0] aft;
  } berr_row_type;

  logic                       CLOCK = 1'b0;
  logic                       RST_N = 1'b0;
  logic                       LINK_RST_N = 1'b1;
  logic [31:0]                COR_EVENTS = 32'h0000_0000;
  logic [31:0]                SEC_EVENTS = 32'h0000_0000;
  berr_pkg::berr_log_type     LOG_CAPTURE = '0;
  berr_pkg::berr_axi_req_type req;
  berr_pkg::berr_axi_rsp_type rsp;
  logic                       gen_en;
  logic                       chk_en;
  logic                       cor_rep;
  logic                       fat_rep;
  logic                       nonfat_rep;
  int                         num_errors = 0;
  int                         tests_run = 0;
  logic [31:0]                q;
  logic [1:0]                 r;
  // Reset value, then value read after writing all ones
  berr_row_type               rows [10] = '{
    '{12'h110, 32'h0000_0000, 32'h0000_0000}, '{12'h114, 32'h0000_0000, 32'h0000_11C1},
    '{12'h118, 32'h0000_00A0, 32'h0000_01E0}, '{12'h11C, 32'h0000_0000, 32'h0000_0000},
    '{12'h120, 32'h0000_0000, 32'h0000_0000}, '{12'h124, 32'h0000_0000, 32'h0000_0000},
    '{12'h128, 32'h0000_0000, 32'h0000_0000}, '{12'h12C, 32'h0000_0000, 32'h0000_0000},
    '{12'h130, 32'h0000_17A8, 32'h0000_3FEF}, '{12'h134, 32'h0000_1340, 32'h0000_3FEF}};

  always #2.5 CLOCK = ~CLOCK;

  berr_host u_host (.clock(CLOCK), .req(req), .rsp(rsp));

  berr_regs u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .LINK_RST_N(LINK_RST_N), .AXI_REQ(req), .AXI_RSP(rsp),
    .COR_EVENTS(COR_EVENTS), .SEC_EVENTS(SEC_EVENTS), .LOG_CAPTURE(LOG_CAPTURE), .ECRC_GEN_EN(gen_en),
    .ECRC_CHK_EN(chk_en), .COR_REPORT(cor_rep), .SEC_REPORT_FATAL(fat_rep), .SEC_REPORT_NONFATAL(nonfat_rep));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    num_errors += u_host.timeouts;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t: saw %h, expected %h", $time, got, exp);
    end
    if (u_host.timeouts != 0)
      results();
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    u_host.rd(a, q, r);
    chk(q, exp);
  endtask

  task automatic wrf(input logic [11:0] a, input logic [31:0] d);
    u_host.wr(a, d, 4'hF, r);
  endtask

  // Event lasts one cycle; reports are looked at just after the edge that registers them
  task automatic pulse(input logic [31:0] c, input logic [31:0] s);
    @(posedge CLOCK);
    COR_EVENTS <= c;
    SEC_EVENTS <= s;
    @(posedge CLOCK);
    COR_EVENTS <= 32'h0000_0000;
    SEC_EVENTS <= 32'h0000_0000;
    #1;
  endtask

  task automatic power_reset();
    @(posedge CLOCK);
    RST_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    RST_N <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    power_reset();
    foreach (rows[i])
    begin
      rdc(rows[i].a, rows[i].rst);
      wrf(rows[i].a, 32'hFFFF_FFFF);
      rdc(rows[i].a, rows[i].aft);
    end
    chk({30'h0, gen_en, chk_en}, 32'h0000_0003);
    u_host.wr(12'h200, 32'hFFFF_FFFF, 4'hF, r);
    chk({30'h0, r}, {30'h0, berr_pkg::RESP_SLVERR});
    rdc(12'h10C, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, berr_pkg::RESP_SLVERR});
    wrf(12'h114, 32'h0000_0000);
    wrf(12'h130, 32'h0000_0000);
    wrf(12'h134, 32'h0000_1000);
    pulse(32'hFFFF_FFFF, 32'h0000_0000);
    chk({31'h0, cor_rep}, 32'h0000_0001);
    rdc(12'h110, 32'h0000_11C1);
    wrf(12'h110, 32'h0000_0001);
    rdc(12'h110, 32'h0000_11C0);
    // Masked event: recorded, never reported
    wrf(12'h114, 32'h0000_11C1);
    pulse(32'hFFFF_FFFF, 32'h0000_0000);
    chk({31'h0, cor_rep}, 32'h0000_0000);
    rdc(12'h110, 32'h0000_11C1);
    pulse(32'h0000_0000, 32'h0000_2000);
    chk({30'h0, fat_rep, nonfat_rep}, 32'h0000_0001);
    pulse(32'h0000_0000, 32'h0000_1000);
    chk({30'h0, fat_rep, nonfat_rep}, 32'h0000_0002);
    wrf(12'h130, 32'h0000_0800);
    pulse(32'h0000_0000, 32'h0000_0800);
    chk({30'h0, fat_rep, nonfat_rep}, 32'h0000_0000);
    rdc(12'h12C, 32'h0000_3800);
    pulse(32'h0000_0000, 32'hFFFF_FFFF);
    rdc(12'h12C, 32'h0000_3FEF);
    @(posedge CLOCK);
    LOG_CAPTURE <= '{1'b1, 5'h13, 128'h0001_0203_0405_0607_0809_0A0B_0C0D_0E0F};
    @(posedge CLOCK);
    LOG_CAPTURE.valid <= 1'b0;
    for (int i = 0; i < 4; i++)
      rdc(12'h11C + 12'(4 * i), {8'(4 * i), 8'(4 * i + 1), 8'(4 * i + 2), 8'(4 * i + 3)});
    rdc(12'h118, 32'h0000_01F3);
    // Lane 0 only: the byte holding bit 12 must not change
    u_host.wr(12'h134, 32'h0000_0000, 4'h1, r);
    rdc(12'h134, 32'h0000_1000);
    @(posedge CLOCK);
    LINK_RST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    LINK_RST_N <= 1'b1;
    rdc(12'h12C, 32'h0000_3FEF);
    rdc(12'h118, 32'h0000_01F3);
    rdc(12'h130, 32'h0000_0800);
    power_reset();
    rdc(12'h130, 32'h0000_17A8);
    rdc(12'h118, 32'h0000_00A0);
    results();
  end
endmodule
